// ==== iop_pkg.sv ====
// Constants shared by the port pin logic
package iop_pkg;
  localparam int IOP_WIDTH = 8;
  localparam logic [7:0] IOP_LATCH_RST = 8'hff;
  localparam logic [7:0] IOP_ADDR_RST = 8'h00;
  localparam int IOP_RXD_BIT = 0;
  localparam int IOP_TXD_BIT = 1;
  localparam int IOP_IRQ_FIRST = 4;
  // Edge polarity per interrupt input 2..5: 1 = rising
  localparam logic [3:0] IOP_IRQ_RISING = 4'h5;
  // Strong high driver pulse length
  localparam int IOP_CLK_MHZ = 100;
  localparam int IOP_KICK_NS = 20;
  localparam int IOP_KICK_CYC_I = (IOP_KICK_NS * IOP_CLK_MHZ) / 1000;
  localparam logic [3:0] IOP_KICK_CYC =
    (IOP_KICK_CYC_I < 1) ? 4'h1 : 4'(IOP_KICK_CYC_I);
endpackage : iop_pkg

// ==== iop_qbit.sv ====
// One quasi-bidirectional pin with its strong high kick
`timescale 1ns/10ps
module iop_qbit
  import iop_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Effective drive level
  input wire logic level_i,
  // Pin controls
  output logic pull_dn_o,
  output logic kick_hi_o
);
  typedef struct packed {
    logic prev;
    logic pd;
    logic kick;
    logic [3:0] cnt;
  } iop_qbit_type;
  iop_qbit_type s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.prev = level_i;
    s_nxt.pd = ~level_i;
    if (level_i && !s_r.prev)
    begin
      s_nxt.kick = 1'b1;
      s_nxt.cnt = IOP_KICK_CYC;
    end
    else if (s_r.kick)
    begin
      s_nxt.cnt = s_r.cnt - 4'h1;
      if (s_r.cnt == 4'h1)
        s_nxt.kick = 1'b0;
    end
    if (!level_i)
      s_nxt.kick = 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '{prev: 1'b1, pd: 1'b0, kick: 1'b0, cnt: 4'h0};
    else
      s_r <= s_nxt;
  end

  assign pull_dn_o = s_r.pd;
  assign kick_hi_o = s_r.kick;

  property p_kick_len;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(s_r.kick) |-> s_r.kick [*2] ##1 !s_r.kick;
  endproperty
  a_kick_len: assert property (p_kick_len)
    else $error("kick pulse length wrong");

  property p_pd_follow;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !level_i |=> s_r.pd && !s_r.kick;
  endproperty
  a_pd_follow: assert property (p_pd_follow)
    else $error("pulldown not on after zero");
endmodule : iop_qbit

// ==== iop_port_pins.sv ====
// Pin logic: ext irqs, address-high pins, third general port
// Summary of operation
// - Port one bit 4 rising edge irq
// - Port one bit 5 falling edge irq
// - Port one bit 6 rising edge irq
// - Port one bit 7 falling edge irq
// - Address pins carry access address bits 15..8
// - Latch readable, writable, driven to pins only on indirect byte moves
// - Indirect byte moves use latch as high byte
// - Third port bidirectional with alternate functions
// - Reset sets third port latch all ones
// - One means input; pin read returns level
// - Zero enables strong pulldown until one written
// - Rising write gives brief strong high drive
// - Bit 0 serial receive, bit 1 transmit
`timescale 1ns/10ps
module iop_port_pins
  import iop_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Interrupt pins, first port bits 7..4
  input wire logic [3:0] ext_irq_pins_i,
  output logic [3:0] ext_irq_req_o,
  // External memory access from core
  input wire logic mem_acc_i,
  input wire logic ind8_acc_i,
  input wire logic [7:0] mem_addr_hi_i,
  output logic [7:0] addr_high_pins_o,
  // Address-high latch, core side
  input wire logic addr_high_we_i,
  input wire logic [7:0] addr_high_wdata_i,
  output logic [7:0] addr_high_latch_o,
  // Third port, core side
  input wire logic p3_we_i,
  input wire logic [7:0] p3_wdata_i,
  output logic [7:0] p3_latch_o,
  output logic [7:0] p3_pin_rd_o,
  // Alternate functions
  input wire logic [7:0] p3_alt_en_i,
  input wire logic [7:0] p3_alt_out_i,
  output logic serial0_rx_o,
  // Third port pins
  input wire logic [7:0] p3_pins_i,
  output logic [7:0] p3_pull_dn_o,
  output logic [7:0] p3_kick_hi_o
);
  typedef struct packed {
    logic [3:0] irq_s1;
    logic [3:0] irq_s2;
    logic [3:0] irq_prev;
    logic [3:0] irq_req;
    logic [7:0] ah_latch;
    logic [7:0] ah_pins;
    logic [7:0] p3_latch;
    logic [7:0] p3_s1;
    logic [7:0] p3_s2;
    logic [7:0] p3_level;
  } iop_port_type;

  iop_port_type s_r, s_nxt;
  // Reset release chain, kept apart as it uses the raw reset
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [7:0] pd_w;
  logic [7:0] kick_w;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.irq_s1 = ext_irq_pins_i;
    s_nxt.irq_s2 = s_r.irq_s1;
    s_nxt.irq_prev = s_r.irq_s2;
    s_nxt.irq_req[0] = s_r.irq_s2[0] & ~s_r.irq_prev[0];
    s_nxt.irq_req[1] = ~s_r.irq_s2[1] & s_r.irq_prev[1];
    s_nxt.irq_req[2] = s_r.irq_s2[2] & ~s_r.irq_prev[2];
    s_nxt.irq_req[3] = ~s_r.irq_s2[3] & s_r.irq_prev[3];
    if (addr_high_we_i)
      s_nxt.ah_latch = addr_high_wdata_i;
    if (ind8_acc_i)
      s_nxt.ah_pins = s_r.ah_latch;
    else if (mem_acc_i)
      s_nxt.ah_pins = mem_addr_hi_i;
    if (p3_we_i)
      s_nxt.p3_latch = p3_wdata_i;
    s_nxt.p3_s1 = p3_pins_i;
    s_nxt.p3_s2 = s_r.p3_s1;
    s_nxt.p3_level = s_nxt.p3_latch &
      (~p3_alt_en_i | p3_alt_out_i);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r.irq_s1 <= 4'hf;
      s_r.irq_s2 <= 4'hf;
      s_r.irq_prev <= 4'hf;
      s_r.irq_req <= 4'h0;
      s_r.ah_latch <= IOP_ADDR_RST;
      s_r.ah_pins <= IOP_ADDR_RST;
      s_r.p3_latch <= IOP_LATCH_RST;
      s_r.p3_s1 <= IOP_LATCH_RST;
      s_r.p3_s2 <= IOP_LATCH_RST;
      s_r.p3_level <= IOP_LATCH_RST;
    end
    else
    begin
      s_r.irq_s1 <= s_nxt.irq_s1;
      s_r.irq_s2 <= s_nxt.irq_s2;
      s_r.irq_prev <= s_nxt.irq_prev;
      s_r.irq_req <= s_nxt.irq_req;
      s_r.ah_latch <= s_nxt.ah_latch;
      s_r.ah_pins <= s_nxt.ah_pins;
      s_r.p3_latch <= s_nxt.p3_latch;
      s_r.p3_s1 <= s_nxt.p3_s1;
      s_r.p3_s2 <= s_nxt.p3_s2;
      s_r.p3_level <= s_nxt.p3_level;
    end
  end

  genvar g;
  generate
    for (g = 0; g < IOP_WIDTH; g++)
    begin : g_qbit
      iop_qbit u_qbit (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .level_i(s_r.p3_level[g]),
        .pull_dn_o(pd_w[g]),
        .kick_hi_o(kick_w[g])
      );
    end
  endgenerate

  assign ext_irq_req_o = s_r.irq_req;
  assign addr_high_pins_o = s_r.ah_pins;
  assign addr_high_latch_o = s_r.ah_latch;
  assign p3_latch_o = s_r.p3_latch;
  assign p3_pin_rd_o = s_r.p3_s2;
  assign serial0_rx_o = s_r.p3_s2[IOP_RXD_BIT];
  assign p3_pull_dn_o = pd_w;
  assign p3_kick_hi_o = kick_w;

  property p_irq_rise;
    @(posedge sys_clk_i) disable iff (!rst_n)
      $rose(s_r.irq_s2[0]) |=> ext_irq_req_o[0] ##1 !ext_irq_req_o[0];
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq input 2 rising edge missed");

  property p_irq_fall;
    @(posedge sys_clk_i) disable iff (!rst_n)
      $fell(s_r.irq_s2[1]) |=> ext_irq_req_o[1];
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq input 3 falling edge missed");

  property p_irq4;
    @(posedge sys_clk_i) disable iff (!rst_n)
      ext_irq_req_o[2] |-> $past(s_r.irq_s2[2]) && !$past(s_r.irq_prev[2]);
  endproperty
  a_irq4: assert property (p_irq4)
    else $error("irq input 4 request without rising edge");

  property p_irq5;
    @(posedge sys_clk_i) disable iff (!rst_n)
      $fell(s_r.irq_s2[3]) |=> ext_irq_req_o[3];
  endproperty
  a_irq5: assert property (p_irq5)
    else $error("irq input 5 falling edge missed");

  property p_addr;
    @(posedge sys_clk_i) disable iff (!rst_n)
      mem_acc_i && !ind8_acc_i |=> addr_high_pins_o == $past(mem_addr_hi_i);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address high pins wrong");

  property p_latch_hold;
    @(posedge sys_clk_i) disable iff (!rst_n)
      !mem_acc_i && !ind8_acc_i |=> $stable(addr_high_pins_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch leaked onto address pins");

  property p_ind8;
    @(posedge sys_clk_i) disable iff (!rst_n)
      ind8_acc_i |=> addr_high_pins_o == $past(addr_high_latch_o);
  endproperty
  a_ind8: assert property (p_ind8)
    else $error("indirect access high byte wrong");

  property p_pd;
    @(posedge sys_clk_i) disable iff (!rst_n)
      p3_we_i |=> ##1 ((p3_pull_dn_o | $past(p3_wdata_i, 2)) == 8'hff);
  endproperty
  a_pd: assert property (p_pd)
    else $error("pulldown not enabled after zero write");

  property p_rd_sync;
    @(posedge sys_clk_i) disable iff (!rst_n)
      $past(rst_n, 2) |-> p3_pin_rd_o == $past(p3_pins_i, 2);
  endproperty
  a_rd_sync: assert property (p_rd_sync)
    else $error("pin read does not follow pin level");

  property p_no_fight;
    @(posedge sys_clk_i) disable iff (!rst_n)
      (p3_pull_dn_o & p3_kick_hi_o) == 8'h00;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("pin driven high and low at once");
endmodule : iop_port_pins

// ==== iop_ext_model.sv ====
// External load and weak pullup on the third port pins
`timescale 1ns/10ps
module iop_ext_model
  import iop_pkg::*;
(
  // Device drive controls
  input wire logic [7:0] pull_dn_i,
  input wire logic [7:0] kick_hi_i,
  // External load pulling low
  input wire logic [7:0] ext_low_i,
  // Resolved pin levels
  output logic [7:0] pins_o
);
  // Strong drivers beat the load, load beats the pullup
  always_comb
  begin
    for (int b = 0; b < IOP_WIDTH; b++)
      pins_o[b] = pull_dn_i[b] ? 1'b0 :
        kick_hi_i[b] ? 1'b1 :
        ext_low_i[b] ? 1'b0 : 1'b1;
  end
endmodule : iop_ext_model

// ==== iop_port_pins_tb_top.sv ====
// Self-checking bench for the port pin logic
`timescale 1ns/10ps
module iop_port_pins_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] irq_pins = 4'hf;
  logic [3:0] irq_req;
  logic acc = 1'b0;
  logic ind8 = 1'b0;
  logic ah_we = 1'b0;
  logic p3_we = 1'b0;
  logic [7:0] hi = 8'h00;
  logic [7:0] ah_wd = 8'h00;
  logic [7:0] p3_wd = 8'hff;
  logic [7:0] alt_en = 8'h00;
  logic [7:0] alt_out = 8'hff;
  logic [7:0] ext_low = 8'h00;
  logic [7:0] ah_pins, ah_latch, p3_latch, p3_rd, pins, p3_pd, p3_kick;
  logic rx;
  int bad_count = 0;
  int check_count = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  iop_port_pins u_dut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .ext_irq_pins_i(irq_pins), .ext_irq_req_o(irq_req),
    .mem_acc_i(acc), .ind8_acc_i(ind8), .mem_addr_hi_i(hi),
    .addr_high_pins_o(ah_pins), .addr_high_we_i(ah_we),
    .addr_high_wdata_i(ah_wd), .addr_high_latch_o(ah_latch),
    .p3_we_i(p3_we), .p3_wdata_i(p3_wd), .p3_latch_o(p3_latch),
    .p3_pin_rd_o(p3_rd), .p3_alt_en_i(alt_en), .p3_alt_out_i(alt_out),
    .serial0_rx_o(rx), .p3_pins_i(pins), .p3_pull_dn_o(p3_pd),
    .p3_kick_hi_o(p3_kick));
  iop_ext_model u_ext (.pull_dn_i(p3_pd), .kick_hi_i(p3_kick),
    .ext_low_i(ext_low), .pins_o(pins));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic p3_write(input logic [7:0] v);
    p3_we = 1'b1;
    p3_wd = v;
    cyc(1);
    p3_we = 1'b0;
  endtask : p3_write
  task automatic p3_scn();
    int kicks;
    chk(p3_latch, 8'hff);
    chk(p3_pd | p3_kick, 8'h00);
    chk(p3_rd, 8'hff);
    p3_write(8'hfe);
    cyc(5);
    chk(p3_pd, 8'h01);
    chk(p3_latch, 8'hfe);
    chk(p3_rd, 8'hfe);
    chk({7'h00, rx}, 8'h00);
    p3_write(8'hff);
    kicks = 0;
    repeat (8)
    begin
      @(negedge clk);
      if (p3_kick[0] === 1'b1)
        kicks++;
    end
    chk(8'(kicks), 8'h02);
    chk(p3_pd, 8'h00);
    ext_low = 8'h08;
    cyc(4);
    chk(p3_rd, 8'hf7);
    ext_low = 8'h00;
    alt_en = 8'h02;
    alt_out = 8'h00;
    cyc(5);
    chk(p3_pd, 8'h02);
    alt_out = 8'h02;
    cyc(5);
    chk(p3_pd, 8'h00);
  endtask : p3_scn
  task automatic irq_scn();
    int hits;
    for (int i = 0; i < 4; i++)
      for (int v = 0; v <= 1; v++)
      begin
        irq_pins[i] = v[0];
        hits = 0;
        repeat (8)
        begin
          @(negedge clk);
          if (irq_req[i] === 1'b1)
            hits++;
        end
        chk(8'(hits), 8'(((i % 2) == 0) == v[0]));
      end
  endtask : irq_scn
  task automatic addr_scn();
    ah_we = 1'b1;
    ah_wd = 8'h5a;
    cyc(1);
    ah_we = 1'b0;
    cyc(2);
    chk(ah_latch, 8'h5a);
    chk(ah_pins, 8'h00);
    acc = 1'b1;
    hi = 8'hc3;
    cyc(1);
    acc = 1'b0;
    cyc(2);
    chk(ah_pins, 8'hc3);
    acc = 1'b1;
    ind8 = 1'b1;
    cyc(1);
    acc = 1'b0;
    ind8 = 1'b0;
    cyc(2);
    chk(ah_pins, 8'h5a);
  endtask : addr_scn
  task automatic close_out();
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    cyc(4);
    p3_scn();
    irq_scn();
    addr_scn();
    close_out();
  end
endmodule : iop_port_pins_tb_top
